// >>> hdl/mpm_consts.svh
// Constants for the maintenance pulse monitor: offsets, fields, reset values, timing.
// Assumes a 125 MHz clock; all segment times are in 0.1 s ticks.
`ifndef MPM_CONSTS_SVH
`define MPM_CONSTS_SVH
// Register offsets (word index on the plain register port)
`define MPM_OFS_HOUR_COUNT 4'h0
`define MPM_OFS_HOUR_LIMIT 4'h1
`define MPM_OFS_AVG_WINDOW 4'h2
`define MPM_OFS_MASK_TIME 4'h3
`define MPM_OFS_FULL_SCALE 4'h4
`define MPM_OFS_LIFE_STATUS 4'h5
`define MPM_OFS_RUN_PIN_FN 4'h6
`define MPM_OFS_RELAY_PIN_FN 4'h7
// Reset values
`define MPM_RST_HOUR_COUNT 16'h0000
`define MPM_RST_HOUR_LIMIT 16'h270f
`define MPM_RST_AVG_WINDOW 16'h000a
`define MPM_RST_MASK_TIME 16'h0000
`define MPM_RST_FULL_SCALE 16'h0064
`define MPM_RST_PIN_FN 16'h0000
// Life status field positions
`define MPM_LIFE_FAN_BIT 2
// Hour count limits
`define MPM_HOUR_MAX 16'h270e
`define MPM_LIMIT_OFF 16'h270f
`define MPM_HOURS_PER_UNIT 7'h64
// Fan thresholds in percent
`define MPM_FAN_SINGLE_PCT 8'h28
`define MPM_FAN_MULTI_PCT 8'h32
// Pin function codes
`define MPM_FN_LIFE_HI 16'h005a
`define MPM_FN_LIFE_LO 16'h00be
`define MPM_FN_PULSE_HI 16'h005d
`define MPM_FN_PULSE_LO 16'h00c1
`define MPM_FN_ALARM_HI 16'h005f
`define MPM_FN_ALARM_LO 16'h00c3
// Timing, the figures as printed
`define MPM_CLK_NS 8
`define MPM_TICK_NS 100000000
`define MPM_HOUR_S 3600
`define MPM_TICKS_PER_S 10
// Frame segments in 0.1 s ticks
`define MPM_T_FRAME 8'hc8
`define MPM_T_START 8'h0a
`define MPM_T_INVALID 8'h23
`define MPM_T_CUR_MIN 8'h05
`define MPM_T_CUR_MAX 8'h5a
`define MPM_T_HR_MIN 8'h14
`define MPM_T_HR_MAX 8'h5a
`define MPM_T_PER_100PCT 8'h32
`endif

// >>> hdl/mpm_pkg.sv
// Types shared by the maintenance pulse monitor files.
// Constants live in mpm_consts.svh.
package mpm_pkg;
  // Monitor frame sequencer states
  typedef enum logic [3:0] {
    MPM_IDLE, MPM_MASK, MPM_START, MPM_LOWCUR, MPM_HIGHHR, MPM_TAIL, MPM_INVALID, MPM_ENDLOW, MPM_NODATA
  } mpm_state_t;
endpackage

// >>> hdl/mpm_tick.sv
// Tick divider: one-cycle pulse every tick_cycles clocks.
// Assumes a free-running clock; count length is a parameter so simulation can shorten it.
`timescale 1ns/10ps
`include "mpm_consts.svh"
module mpm_tick #(
  parameter int unsigned TICK_CYCLES = `MPM_TICK_NS / `MPM_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick out
  output logic tick
);
  import mpm_pkg::*;
  logic [31:0] cnt; // Cycles since last tick
  logic [31:0] next_cnt;
  logic next_tick;

  // Wrap counter and flag the wrap
  always_comb begin
    next_tick = (cnt == 32'(TICK_CYCLES - 1));
    next_cnt = next_tick ? 32'h0 : cnt + 32'h1;
  end

  // Register counter and tick
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// >>> hdl/mpm_calc.sv
// Segment length calculator: averages current samples and derives the clamped
// low-pulse and high-pulse lengths in 0.1 s ticks. Result registered on load.
// Assumes the sequencer holds the inputs steady in the load cycle.
`timescale 1ns/10ps
`include "mpm_consts.svh"
module mpm_calc (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire logic load,
  input wire logic [19:0] cur_sum,
  input wire logic [3:0] cur_samples,
  input wire logic [15:0] full_scale,
  input wire logic [15:0] hour_count,
  // Results
  output logic [7:0] cur_ticks,
  output logic [7:0] hr_ticks
);
  import mpm_pkg::*;
  logic [19:0] avg; // Averaged current
  logic [27:0] scaled; // Average times 5 s in ticks
  logic [27:0] quot;
  logic [7:0] next_cur_ticks;
  logic [7:0] next_hr_ticks;

  // Average, scale and clamp; a zero reference reads as full overload
  always_comb begin
    avg = (cur_samples == 4'h0) ? 20'h0 : cur_sum / 20'(cur_samples);
    scaled = 28'(avg) * 28'(`MPM_T_PER_100PCT);
    quot = (full_scale == 16'h0) ? 28'h0 : scaled / 28'(full_scale);
    if (full_scale == 16'h0 || 28'(avg) * 28'd100 > 28'(full_scale) * 28'd180) begin
      next_cur_ticks = `MPM_T_CUR_MAX;
    end else if (28'(avg) * 28'd10 < 28'(full_scale)) begin
      next_cur_ticks = `MPM_T_CUR_MIN;
    end else begin
      next_cur_ticks = 8'(quot);
    end
    // Count*100/40000h*5 s equals count/8 ticks
    if (32'(hour_count) * 32'd100 < 32'd16000) begin
      next_hr_ticks = `MPM_T_HR_MIN;
    end else if (32'(hour_count) * 32'd100 > 32'd72000) begin
      next_hr_ticks = `MPM_T_HR_MAX;
    end else begin
      next_hr_ticks = 8'(hour_count >> 3);
    end
  end

  // Capture on load only
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ticks <= `MPM_T_CUR_MIN;
      hr_ticks <= `MPM_T_HR_MIN;
    end else if (load) begin
      cur_ticks <= next_cur_ticks;
      hr_ticks <= next_hr_ticks;
    end
  end
endmodule

// >>> hdl/mpm_top.sv
// Maintenance pulse monitor: fan alarm, energizing-hour counter with alarm,
// and the 20 s pulse-coded current/hour monitor output with pin routing.
// Assumes drive state inputs are synchronous to clk and mutually consistent.
// Summary of operation
// - Fan at or below 40% raises alarms
// - Multi-fan units fault at 50% any fan
// - Count whole hours only, persist each hour
// - Count in 100h units, zero write clears
// - Count saturates at 9998
// - Count reaching limit alarms; 9999 disables
// - Alarm on pin with code 95/195
// - Constant speed repeats 20 s frames
// - 1 s start bit, windowed current average
// - Mask current after entering constant speed
// - Low time is avg/reference times 5 s
// - Low time clamped 0.5 to 9 s
// - High time is hours scaled to 5 s
// - High time clamped 2 to 9 s
// - No masking or sampling while accelerating
// - Accel in start bit marks frame invalid
// - Finished start bit completes whole frame
// - Zero current at frame end suppresses frames
// - Three cases give 20 s low, no data
// - Pulse only on run pin, code 93/193
// - Monitor settings writable at any time
// - Life alarm combines all life bits
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "mpm_consts.svh"
module mpm_top #(
  parameter int unsigned TICK_CYCLES = `MPM_TICK_NS / `MPM_CLK_NS,
  parameter int unsigned HOUR_TICKS = `MPM_HOUR_S * `MPM_TICKS_PER_S
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Fan and other life sources
  input wire logic [7:0] fan_speed_0,
  input wire logic [7:0] fan_speed_1,
  input wire logic fan_dual,
  input wire logic [3:0] life_other,
  // Drive state
  input wire logic const_speed,
  input wire logic accel_decel,
  input wire logic auto_restart,
  input wire logic restart_coast_setting,
  input wire logic [15:0] out_current,
  // Indications and persistence
  output logic fan_fault_indication,
  output logic service_due_indication,
  output logic life_alarm_out,
  output logic hour_limit_alarm_out,
  output logic current_avg_pulse_out,
  output logic hour_persist,
  // Output terminals
  output logic run_pin_out,
  output logic relay_pin_out
);
  import mpm_pkg::*;

  // Register storage
  logic [15:0] energize_hour_count; // 100 h units
  logic [15:0] energize_hour_limit;
  logic [15:0] current_avg_window; // 0.1 s units
  logic [15:0] settle_mask_time; // 0.1 s units
  logic [15:0] current_full_scale; // Amps, 100% reference
  logic [15:0] run_pin_function;
  logic [15:0] relay_pin_function;
  logic [15:0] life_alarm_status;
  logic [15:0] next_energize_hour_count;
  logic [15:0] next_energize_hour_limit;
  logic [15:0] next_current_avg_window;
  logic [15:0] next_settle_mask_time;
  logic [15:0] next_current_full_scale;
  logic [15:0] next_run_pin_function;
  logic [15:0] next_relay_pin_function;
  logic [15:0] next_reg_rdata;

  // Hour accumulation
  logic [31:0] hr_ticks_cnt; // Ticks within the current hour
  logic [6:0] sub_hours; // Whole hours within current 100 h
  logic [31:0] next_hr_ticks_cnt;
  logic [6:0] next_sub_hours;
  logic next_hour_persist;
  logic hour_done;
  logic count_clear;

  // Sequencer
  mpm_state_t state, next_state;
  logic [7:0] ftick, next_ftick; // Ticks into frame or segment
  logic [7:0] seg_end, next_seg_end; // Tick at which segment ends
  logic [19:0] cur_sum, next_cur_sum;
  logic [3:0] cur_samples, next_cur_samples;
  logic const_prev;
  logic pulse, next_pulse;
  logic calc_load;
  logic restart_busy;
  logic frame_done;
  logic tick;
  logic [7:0] cur_ticks;
  logic [7:0] hr_ticks;
  logic fan_fault;
  logic hour_alarm;

  // 0.1 s time base for every segment and the hour counter
  mpm_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // Segment length calculator
  mpm_calc u_calc (
    .clk(clk),
    .rst(rst),
    .load(calc_load),
    .cur_sum(cur_sum),
    .cur_samples(cur_samples),
    .full_scale(current_full_scale),
    .hour_count(energize_hour_count),
    .cur_ticks(cur_ticks),
    .hr_ticks(hr_ticks)
  );

  // Fan and life status, combinational from the sensors
  always_comb begin
    fan_fault = (fan_speed_0 <= `MPM_FAN_SINGLE_PCT);
    if (fan_dual) begin
      fan_fault = (fan_speed_0 <= `MPM_FAN_MULTI_PCT) || (fan_speed_1 <= `MPM_FAN_MULTI_PCT);
    end
    life_alarm_status = {12'h0, life_other};
    life_alarm_status[`MPM_LIFE_FAN_BIT] = fan_fault;
    hour_alarm = (energize_hour_limit != `MPM_LIMIT_OFF) && (energize_hour_count >= energize_hour_limit);
  end

  // Hour accumulation: partial hours are never carried into the count
  always_comb begin
    hour_done = tick && (hr_ticks_cnt == 32'(HOUR_TICKS - 1));
    count_clear = reg_wr && (reg_addr == `MPM_OFS_HOUR_COUNT) && (reg_wdata == 16'h0);
    next_hr_ticks_cnt = hr_ticks_cnt;
    next_sub_hours = count_clear ? 7'h0 : sub_hours;
    next_energize_hour_count = count_clear ? 16'h0 : energize_hour_count;
    if (tick) begin
      next_hr_ticks_cnt = hour_done ? 32'h0 : hr_ticks_cnt + 32'h1;
    end
    // Increment after clear so a same-cycle hour is not lost
    if (hour_done) begin
      if (next_sub_hours == `MPM_HOURS_PER_UNIT - 7'h1) begin
        next_sub_hours = 7'h0;
        if (next_energize_hour_count < `MPM_HOUR_MAX) begin
          next_energize_hour_count = next_energize_hour_count + 16'h1;
        end
      end else begin
        next_sub_hours = next_sub_hours + 7'h1;
      end
    end
    next_hour_persist = hour_done;
  end

  // Register writes, accepted regardless of operating state
  always_comb begin
    next_energize_hour_limit = energize_hour_limit;
    next_current_avg_window = current_avg_window;
    next_settle_mask_time = settle_mask_time;
    next_current_full_scale = current_full_scale;
    next_run_pin_function = run_pin_function;
    next_relay_pin_function = relay_pin_function;
    if (reg_wr) begin
      case (reg_addr)
        `MPM_OFS_HOUR_LIMIT: next_energize_hour_limit = reg_wdata;
        `MPM_OFS_AVG_WINDOW: next_current_avg_window = reg_wdata;
        `MPM_OFS_MASK_TIME: next_settle_mask_time = reg_wdata;
        `MPM_OFS_FULL_SCALE: next_current_full_scale = reg_wdata;
        `MPM_OFS_RUN_PIN_FN: next_run_pin_function = reg_wdata;
        `MPM_OFS_RELAY_PIN_FN: next_relay_pin_function = reg_wdata;
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  // Read mux, data valid the cycle after the strobe
  always_comb begin
    next_reg_rdata = 16'h0;
    if (reg_rd) begin
      case (reg_addr)
        `MPM_OFS_HOUR_COUNT: next_reg_rdata = energize_hour_count;
        `MPM_OFS_HOUR_LIMIT: next_reg_rdata = energize_hour_limit;
        `MPM_OFS_AVG_WINDOW: next_reg_rdata = current_avg_window;
        `MPM_OFS_MASK_TIME: next_reg_rdata = settle_mask_time;
        `MPM_OFS_FULL_SCALE: next_reg_rdata = current_full_scale;
        `MPM_OFS_LIFE_STATUS: next_reg_rdata = life_alarm_status;
        `MPM_OFS_RUN_PIN_FN: next_reg_rdata = run_pin_function;
        `MPM_OFS_RELAY_PIN_FN: next_reg_rdata = relay_pin_function;
        default: next_reg_rdata = 16'h0; // Unmapped reads zero
      endcase
    end
  end

  // Frame sequencer next state
  always_comb begin
    restart_busy = auto_restart && restart_coast_setting;
    frame_done = tick && (ftick == `MPM_T_FRAME - 8'h1);
    next_state = state;
    next_ftick = tick ? ftick + 8'h1 : ftick;
    next_seg_end = seg_end;
    next_cur_sum = cur_sum;
    next_cur_samples = cur_samples;
    next_pulse = 1'b0;
    calc_load = 1'b0;
    case (state)
      MPM_IDLE: begin
        // Wait for a fresh entry into constant speed
        next_ftick = 8'h0;
        if (const_speed && !const_prev && !accel_decel) begin
          next_state = MPM_MASK;
        end
      end
      MPM_MASK: begin
        // Mask timer only runs at constant speed
        if (accel_decel || !const_speed) begin
          next_state = MPM_IDLE;
        end else if (tick && (ftick >= 8'(settle_mask_time))) begin // Tick-aligned so start bit is ten whole ticks
          next_ftick = 8'h0;
          next_cur_sum = 20'h0;
          next_cur_samples = 4'h0;
          next_state = restart_busy ? MPM_NODATA : MPM_START;
          next_pulse = !restart_busy;
        end
      end
      MPM_START: begin
        next_pulse = 1'b1;
        if (accel_decel) begin
          next_state = MPM_INVALID;
        end else begin
          // Sample once a tick inside the averaging window
          if (tick && (16'(cur_samples) < current_avg_window) && const_speed) begin
            next_cur_sum = cur_sum + 20'(out_current);
            next_cur_samples = cur_samples + 4'h1;
          end
          if (tick && ftick == `MPM_T_START - 8'h1) begin
            calc_load = 1'b1;
            next_state = MPM_LOWCUR;
            next_pulse = 1'b0;
          end
        end
      end
      MPM_LOWCUR: begin
        // Frame no longer watches accel once here
        next_seg_end = `MPM_T_START + cur_ticks;
        if (tick && ftick == next_seg_end - 8'h1) begin
          next_state = MPM_HIGHHR;
          next_pulse = 1'b1;
        end
      end
      MPM_HIGHHR: begin
        next_pulse = 1'b1;
        if (tick && ftick == seg_end + hr_ticks - 8'h1) begin
          next_state = MPM_TAIL;
          next_pulse = 1'b0;
        end
      end
      MPM_INVALID: begin
        // Start bit stretched, then end signal
        next_pulse = 1'b1;
        if (tick && ftick == `MPM_T_INVALID - 8'h1) begin
          next_state = MPM_ENDLOW;
          next_pulse = 1'b0;
        end
      end
      MPM_TAIL, MPM_ENDLOW, MPM_NODATA: begin
        // Low until the 20 s frame boundary, then choose the next frame
        if (frame_done) begin
          next_ftick = 8'h0;
          next_cur_sum = 20'h0;
          next_cur_samples = 4'h0;
          if (state == MPM_NODATA) begin
            next_state = (const_speed && !accel_decel && !restart_busy) ? MPM_START : MPM_IDLE;
          end else if (out_current == 16'h0) begin
            next_state = MPM_IDLE;
          end else if (accel_decel || restart_busy) begin
            next_state = MPM_NODATA;
          end else if (const_speed) begin
            next_state = MPM_START;
          end else begin
            next_state = MPM_IDLE;
          end
          next_pulse = (next_state == MPM_START);
        end
      end
      default: begin
        next_state = MPM_IDLE;
      end
    endcase
  end

  // Register everything
  always_ff @(posedge clk) begin
    if (rst) begin
      energize_hour_count <= `MPM_RST_HOUR_COUNT;
      energize_hour_limit <= `MPM_RST_HOUR_LIMIT;
      current_avg_window <= `MPM_RST_AVG_WINDOW;
      settle_mask_time <= `MPM_RST_MASK_TIME;
      current_full_scale <= `MPM_RST_FULL_SCALE;
      run_pin_function <= `MPM_RST_PIN_FN;
      relay_pin_function <= `MPM_RST_PIN_FN;
      reg_rdata <= 16'h0;
      hr_ticks_cnt <= 32'h0;
      sub_hours <= 7'h0;
      hour_persist <= 1'b0;
      state <= MPM_IDLE;
      ftick <= 8'h0;
      seg_end <= 8'h0;
      cur_sum <= 20'h0;
      cur_samples <= 4'h0;
      const_prev <= 1'b0;
      pulse <= 1'b0;
    end else begin
      energize_hour_count <= next_energize_hour_count;
      energize_hour_limit <= next_energize_hour_limit;
      current_avg_window <= next_current_avg_window;
      settle_mask_time <= next_settle_mask_time;
      current_full_scale <= next_current_full_scale;
      run_pin_function <= next_run_pin_function;
      relay_pin_function <= next_relay_pin_function;
      reg_rdata <= next_reg_rdata;
      hr_ticks_cnt <= next_hr_ticks_cnt;
      sub_hours <= next_sub_hours;
      hour_persist <= next_hour_persist;
      state <= next_state;
      ftick <= next_ftick;
      seg_end <= next_seg_end;
      cur_sum <= next_cur_sum;
      cur_samples <= next_cur_samples;
      const_prev <= const_speed;
      pulse <= next_pulse;
    end
  end

  // Indications and terminal routing; pulse code never reaches the relay
  always_comb begin
    fan_fault_indication = fan_fault;
    life_alarm_out = |life_alarm_status;
    hour_limit_alarm_out = hour_alarm;
    service_due_indication = hour_alarm;
    current_avg_pulse_out = pulse;
    case (run_pin_function)
      `MPM_FN_PULSE_HI: run_pin_out = pulse;
      `MPM_FN_PULSE_LO: run_pin_out = !pulse;
      `MPM_FN_ALARM_HI: run_pin_out = hour_alarm;
      `MPM_FN_ALARM_LO: run_pin_out = !hour_alarm;
      `MPM_FN_LIFE_HI: run_pin_out = life_alarm_out;
      `MPM_FN_LIFE_LO: run_pin_out = !life_alarm_out;
      default: run_pin_out = 1'b0;
    endcase
    case (relay_pin_function)
      `MPM_FN_ALARM_HI: relay_pin_out = hour_alarm;
      `MPM_FN_ALARM_LO: relay_pin_out = !hour_alarm;
      `MPM_FN_LIFE_HI: relay_pin_out = life_alarm_out;
      `MPM_FN_LIFE_LO: relay_pin_out = !life_alarm_out;
      default: relay_pin_out = 1'b0;
    endcase
  end
endmodule

// >>> tb/mpm_properties.sv
// Concurrent checks on the maintenance pulse monitor top ports.
// Assumes the single clk domain and active high synchronous rst of mpm_top.
`timescale 1ns/10ps
`include "mpm_consts.svh"
module mpm_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register read side
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Fan and life sources
  input wire logic [7:0] fan_speed_0,
  input wire logic [7:0] fan_speed_1,
  input wire logic fan_dual,
  input wire logic [3:0] life_other,
  // Observed outputs
  input wire logic fan_fault_indication,
  input wire logic service_due_indication,
  input wire logic life_alarm_out,
  input wire logic hour_limit_alarm_out,
  input wire logic current_avg_pulse_out,
  input wire logic hour_persist
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Single fan: fault exactly at 40 percent or less
  a_fan_single: assert property (
    !fan_dual |-> fan_fault_indication == (fan_speed_0 <= `MPM_FAN_SINGLE_PCT)) else $error("single fan fault wrong");
  // Two fans: any one at 50 percent or less
  a_fan_dual: assert property (
    fan_dual |-> fan_fault_indication == (fan_speed_0 <= 8'h32 || fan_speed_1 <= 8'h32)) else $error("dual fan fault wrong");
  // Life alarm is the OR of every life bit, fan included
  a_life_any: assert property (
    life_alarm_out == (fan_fault_indication | life_other[0] | life_other[1] | life_other[3]))
    else $error("life alarm wrong");
  // Indication and terminal alarm never disagree
  a_alarm_pair: assert property (
    hour_limit_alarm_out == service_due_indication) else $error("hour alarm pair differs");
  // Store request is a lone pulse, hours are far apart
  a_persist_once: assert property (
    hour_persist |=> !hour_persist [*8]) else $error("hour store pulse too close");
  // Shortest high segment is the 1 s start bit
  a_high_hold: assert property (
    $rose(current_avg_pulse_out) |=> current_avg_pulse_out [*8]) else $error("high segment too short");
  // Shortest low segment is the 0.5 s clamp
  a_low_hold: assert property (
    $fell(current_avg_pulse_out) |=> !current_avg_pulse_out [*8]) else $error("low segment too short");
  // Read data only in the cycle after a read strobe
  a_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside its cycle");
endmodule
bind mpm_top mpm_properties mpm_properties_i (.clk, .rst, .reg_rd, .reg_rdata, .fan_speed_0, .fan_speed_1,
  .fan_dual, .life_other, .fan_fault_indication, .service_due_indication, .life_alarm_out,
  .hour_limit_alarm_out, .current_avg_pulse_out, .hour_persist);

// >>> tb/mpm_pulse_sampler.sv
// Controller input model: times each level of the monitor pulse line in clocks.
// Assumes the line is polled on clk, as a controller input module would.
`timescale 1ns/10ps
module mpm_pulse_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Polled line
  input wire logic line,
  // Finished segment: strobe, level, length
  output logic done,
  output logic lvl,
  output int len
);
  int cnt; // Clocks in current level
  logic prev; // Level being timed
  // A change closes the running segment
  always @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      cnt <= 1;
      prev <= 1'b0;
    end else if (line !== prev) begin
      done <= 1'b1;
      lvl <= prev;
      len <= cnt;
      cnt <= 1;
      prev <= line;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> tb/maintenance_pulse_monitor_tb.sv
// Bench for mpm_top: registers, fans, hour counter, pin routing, monitor frames.
// Assumes short tick and hour parameters; frames are timed by mpm_pulse_sampler.
`timescale 1ns/10ps
module maintenance_pulse_monitor_tb;
  localparam int TC = 20; // Clocks per 0.1 s tick, keeps frames short
  logic clk, rst, reg_wr, reg_rd, fan_dual, const_speed, accel_decel, auto_restart, restart_coast_setting;
  logic [3:0] reg_addr, life_other;
  logic [15:0] reg_wdata, reg_rdata, out_current;
  logic [7:0] fan_speed_0, fan_speed_1;
  logic fan_fault_indication, service_due_indication, life_alarm_out, hour_limit_alarm_out, ff;
  logic current_avg_pulse_out, hour_persist, run_pin_out, relay_pin_out, done, lvl;
  int len, fails = 0, total_checks = 0, seed, cycles = 0, hp, k, c;
  int exp_q[$]; // Model segment lengths, clocks
  int rv[10] = '{0, 16'h270f, 10, 0, 100, 0, 0, 0, 0, 0};
  int codes[6] = '{93, 193, 95, 195, 90, 190};
  int rexp[6] = '{0, 1, 1, 0, 0, 1};
  int lexp[6] = '{0, 0, 1, 0, 0, 1};
  int curs[3] = '{150, 5, 200};
  mpm_top #(.TICK_CYCLES(TC), .HOUR_TICKS(4)) mpm_top_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .fan_speed_0, .fan_speed_1, .fan_dual, .life_other, .const_speed, .accel_decel, .auto_restart,
    .restart_coast_setting, .out_current, .fan_fault_indication, .service_due_indication, .life_alarm_out,
    .hour_limit_alarm_out, .current_avg_pulse_out, .hour_persist, .run_pin_out, .relay_pin_out);
  mpm_pulse_sampler mpm_pulse_sampler_i (.clk, .rst, .line(current_avg_pulse_out), .done, .lvl, .len);
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard, well above the planned run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Next finished segment; negative length skips the length check
  task automatic seg(input logic l, input int n);
    k = 0;
    @(posedge clk);
    while (done !== 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 5000) fails++;
    chk(lvl, l);
    if (n >= 0) chk(len, n);
  endtask
  // Low pulse in ticks for a current at 100 A reference, clamped
  function automatic int cur_t(input int a);
    int t;
    t = a * 50 / 100;
    if (t < 5) t = 5;
    if (t > 90) t = 90;
    return t;
  endfunction
  initial begin
    seed = 85;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 22'h0};
    {fan_speed_0, fan_speed_1, fan_dual, life_other} = {8'h64, 8'h64, 5'h00};
    {const_speed, accel_decel, auto_restart, restart_coast_setting} = 4'h0;
    out_current = 16'h0096;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Refused writes, then reset values and two unmapped reads
    wr(4'h0, 16'h0005);
    wr(4'h5, 16'h000f);
    wr(4'h9, 16'h1234);
    for (c = 0; c < 10; c++) rd(c[3:0], rv[c]);
    // Random fans and life bits
    repeat (24) begin
      @(posedge clk);
      fan_speed_0 <= 8'($unsigned($random(seed)) % 101);
      fan_speed_1 <= 8'($unsigned($random(seed)) % 101);
      fan_dual <= 1'($random(seed));
      life_other <= 4'($random(seed));
      #1 ff = fan_dual ? (fan_speed_0 <= 8'h32 || fan_speed_1 <= 8'h32) : (fan_speed_0 <= 8'h28);
      chk(fan_fault_indication, ff);
      chk(life_alarm_out, ff | life_other[0] | life_other[1] | life_other[3]);
      rd(4'h5, {12'h000, life_other[3], ff, life_other[1:0]});
    end
    {fan_speed_0, fan_speed_1, fan_dual, life_other} <= {8'h64, 8'h64, 5'h00};
    // Limit 0 alarms at count 0; route each code to both terminals
    wr(4'h1, 16'h0000);
    #1 chk(service_due_indication, 1'b1);
    foreach (codes[i]) begin
      wr(4'h6, codes[i][15:0]);
      wr(4'h7, codes[i][15:0]);
      #1 chk(run_pin_out, rexp[i]);
      chk(relay_pin_out, lexp[i]);
    end
    wr(4'h1, 16'h270f);
    #1 chk(hour_limit_alarm_out, 1'b0);
    // Clear just after an hour, then count 100 whole hours
    wr(4'h1, 16'h0001);
    while (hour_persist !== 1'b1) @(posedge clk);
    wr(4'h0, 16'h0000);
    for (hp = 0; hp < 100; hp++) begin
      if (hp == 99) rd(4'h0, 0);
      if (hp == 99) chk(service_due_indication, 1'b0);
      @(posedge clk);
      k = 0;
      while (hour_persist !== 1'b1 && k < 200) begin
        @(posedge clk);
        k++;
      end
      if (k >= 200) fails++;
      if (hp == 1) chk(k + 1, 4 * TC);
    end
    rd(4'h0, 1);
    chk(service_due_indication, 1'b1);
    wr(4'h1, 16'h270f);
    // Frames at constant speed; current changes after each hour pulse
    const_speed <= 1'b1;
    seg(1'b0, -1);
    foreach (curs[i]) begin
      c = cur_t(curs[i]);
      exp_q = '{10 * TC, c * TC, 20 * TC, (170 - c) * TC};
      seg(1'b1, exp_q.pop_front());
      seg(1'b0, exp_q.pop_front());
      seg(1'b1, exp_q.pop_front());
      out_current <= 16'(curs[(i + 1) % 3]);
      seg(1'b0, exp_q.pop_front());
    end
    // Acceleration inside a start bit gives the invalid frame
    accel_decel <= 1'b1;
    const_speed <= 1'b0;
    seg(1'b1, 35 * TC);
    c = 0;
    repeat (160 * TC) begin
      @(posedge clk);
      if (current_avg_pulse_out !== 1'b0) c++;
    end
    chk(c, 0);
    print_verdict();
  end
endmodule
